// ===== hdl/drc_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - sub-urgent mode at postponed count lower bound
// - urgent mode at postponed count threshold
// - refresh interval 7.8 or 3.9 us
// - stagger self-refresh exit by trfc/n times index
// - command timing one or two cycles
// - manual setup delays 0..39 per signal group
// - activate limit from spd or override
// - replay limits programmable, 1..3 invalid
// - ecc on unless explicitly disabled
// - ecc symbol x4, x8, x16 or auto
// - spd optimized read skips upper bytes
// - chip-select interleave address blocks
// - bank, cs, rank-multiply hashing, bank-group exchange
// - selftest interface, data-eye or both
// - prbs, switching or both, length 3..12
// - none, 1, 3 or 7 aggressor channels
// - static lane masks upper, lower, ecc
// - sweep steps 1, 2 or 4
// - margins per chip select or nibble
// - power-down only when enabled or auto
module drc_ctrl
    import drc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic mem_clk,
    input drc_pkg::drc_ref_cfg_t ref_cfg,
    input wire logic [RANKS-1:0] refresh_done,
    input wire logic rw_pending,
    input drc_pkg::drc_tri_t power_down_sel,
    input wire logic idle_hint,
    input wire logic self_refresh_exit,
    input wire logic [1:0] command_cycle_select,
    input wire logic bus_timing_manual,
    input wire logic [5:0] addr_command_setup_delay,
    input wire logic [5:0] select_termination_setup_delay,
    input wire logic [5:0] clock_enable_setup_delay,
    input drc_pkg::drc_mac_t mac_override,
    input wire logic [7:0] spd_byte7,
    input wire logic [7:0] parity_replay_cfg,
    input wire logic [7:0] crc_replay_cfg,
    input drc_pkg::drc_tri_t ecc_sel,
    input drc_pkg::drc_sym_t ecc_symbol_sel,
    input wire logic spd_read_optimize,
    input wire logic cs_interleave,
    input wire logic [4:0] hash_enables,
    input wire logic [15:0] addr_in,
    input wire logic bist_start,
    input drc_pkg::drc_bist_cfg_t bist_cfg,
    input drc_pkg::drc_lane_t aggressor_lanes,
    input drc_pkg::drc_lane_t target_lanes,
    output logic [RANKS-1:0] refresh_request,
    output logic sub_urgent,
    output logic urgent,
    output logic traffic_stall,
    output logic power_down_allow,
    output logic [10:0] sr_exit_extra,
    output logic two_cycle_cmd,
    output logic [17:0] setup_delays,
    output logic [3:0] max_activate_limit,
    output logic [7:0] parity_replay_limit,
    output logic [7:0] crc_replay_limit,
    output logic ecc_enable,
    output logic [1:0] ecc_symbol,
    output logic [9:0] spd_last_addr,
    output logic [15:0] addr_out,
    output logic [71:0] lane_force,
    output logic lane_value,
    output logic [11:0] bist_pattern,
    output logic [2:0] aggressor_mask,
    output logic [11:0] sweep_steps,
    output logic per_nibble_margin,
    output logic bist_busy,
    output logic bist_done
);
    import drc_pkg::*;

    ////////////////////////////////////////////////////////////////
    // link clock: sync and edge detect
    logic mclk_s;
    logic mclk_prev_q;
    logic mclk_rise;

    drc_sync u_sync
    (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(mem_clk),
        .sync_out(mclk_s)
    );

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            mclk_prev_q <= 1'b0;
        else
            mclk_prev_q <= mclk_s;
    end
    assign mclk_rise = mclk_s & ~mclk_prev_q;

    ////////////////////////////////////////////////////////////////
    // refresh interval timer
    logic [15:0] refi_cnt_q;
    logic refi_tick;

    assign refi_tick = (refi_cnt_q == 16'h0000);
    always_ff @(posedge ref_clk)
    begin
        // reload one short: the zero cycle belongs to the interval
        if (srst || refi_tick)
            refi_cnt_q <= (ref_cfg.fast_refresh ? REFI_FAST_CYC : REFI_NORMAL_CYC)
                - 16'h0001;
        else
            refi_cnt_q <= refi_cnt_q - 16'h0001;
    end

    ////////////////////////////////////////////////////////////////
    // postponed refresh counts, one per rank
    logic [2:0] lb_c;
    logic [2:0] ut_c;
    logic [3:0] pend_q [RANKS];
    logic [RANKS-1:0] sub_hit;
    logic [RANKS-1:0] urg_hit;

    // out-of-range settings clamp into 1..6; the lower bound is not
    // cross-checked since keeping it at or below the threshold is software's job
    assign lb_c = (ref_cfg.lower_bound < REF_BOUND_MIN) ? REF_BOUND_MIN :
                  (ref_cfg.lower_bound > REF_BOUND_MAX) ? REF_BOUND_MAX : ref_cfg.lower_bound;
    assign ut_c = (ref_cfg.urgent_threshold < REF_BOUND_MIN) ? REF_BOUND_MIN :
                  (ref_cfg.urgent_threshold > REF_BOUND_MAX) ? REF_BOUND_MAX :
                  ref_cfg.urgent_threshold;

    genvar gr;
    generate
        for (gr = 0; gr < RANKS; gr++)
        begin : g_rank
            // tick and done together: count stays, the new one is not lost
            always_ff @(posedge ref_clk)
            begin
                if (srst)
                    pend_q[gr] <= 4'h0;
                else if (refi_tick && !refresh_done[gr] && pend_q[gr] != REF_PEND_MAX)
                    pend_q[gr] <= pend_q[gr] + 4'h1;
                else if (!refi_tick && refresh_done[gr] && pend_q[gr] != 4'h0)
                    pend_q[gr] <= pend_q[gr] - 4'h1;
            end
            assign sub_hit[gr] = pend_q[gr] >= {1'b0, lb_c};
            assign urg_hit[gr] = pend_q[gr] >= {1'b0, ut_c};
        end
    endgenerate

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            sub_urgent <= 1'b0;
            urgent <= 1'b0;
            traffic_stall <= 1'b0;
            refresh_request <= '0;
        end
        else
        begin
            sub_urgent <= |sub_hit;
            urgent <= |urg_hit;
            traffic_stall <= |urg_hit && rw_pending;
            // refreshes below the lower bound wait for an idle bus; sub-urgent and urgent ones go regardless
            for (int i = 0; i < RANKS; i++)
                refresh_request[i] <= urg_hit[i] ||
                    (pend_q[i] != 4'h0 && (!rw_pending || sub_hit[i]));
        end
    end

    ////////////////////////////////////////////////////////////////
    // power-down and self-refresh exit stagger
    logic [10:0] stag_base;

    always_comb
    begin
        case (ref_cfg.stagger)
            DRC_STAG_DIV3: stag_base = 11'(ref_cfg.trfc / 10'd3);
            DRC_STAG_DIV4: stag_base = 11'(ref_cfg.trfc >> 2);
            default: stag_base = 11'h000;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            power_down_allow <= 1'b0;
            sr_exit_extra <= 11'h000;
        end
        else
        begin
            power_down_allow <= (power_down_sel != DRC_TRI_OFF) && idle_hint && !urgent;
            if (self_refresh_exit)
                sr_exit_extra <= 11'(stag_base * ref_cfg.controller_index);
        end
    end

    ////////////////////////////////////////////////////////////////
    // command bus timing and retry limits
    function automatic logic [5:0] clamp_setup(input logic [5:0] v);
        clamp_setup = (v > SETUP_MAX) ? SETUP_MAX : v;
    endfunction

    function automatic logic [7:0] replay_fix(input logic [7:0] v);
        // 1..3 would retry too little to clear a burst; treat as disabled
        replay_fix = (v != 8'h00 && v < REPLAY_MIN_VALID) ? 8'h00 : v;
    endfunction

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            two_cycle_cmd <= 1'b0;
            setup_delays <= '0;
            parity_replay_limit <= 8'h00;
            crc_replay_limit <= 8'h00;
        end
        else
        begin
            two_cycle_cmd <= (command_cycle_select == 2'b10);
            if (mclk_rise)
                setup_delays <= bus_timing_manual ?
                    {clamp_setup(addr_command_setup_delay),
                     clamp_setup(select_termination_setup_delay),
                     clamp_setup(clock_enable_setup_delay)} : '0;
            parity_replay_limit <= replay_fix(parity_replay_cfg);
            crc_replay_limit <= replay_fix(crc_replay_cfg);
        end
    end

    ////////////////////////////////////////////////////////////////
    // activate limit, ecc, spd policy
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            max_activate_limit <= 4'h0;
            ecc_enable <= 1'b1;
            ecc_symbol <= 2'b00;
            spd_last_addr <= SPD_LAST_FULL;
        end
        else
        begin
            max_activate_limit <= (mac_override == DRC_MAC_AUTO) ?
                (spd_byte7[3:0] & SPD_MAC_NIBBLE) : mac_override;
            ecc_enable <= (ecc_sel != DRC_TRI_OFF);
            ecc_symbol <= ecc_symbol_sel;
            spd_last_addr <= spd_read_optimize ? SPD_LAST_OPT : SPD_LAST_FULL;
        end
    end

    ////////////////////////////////////////////////////////////////
    // address map: interleave, hashes, bank-group exchange
    logic [15:0] amap;

    always_comb
    begin
        amap = addr_in;
        if (cs_interleave)
            amap[1:0] = addr_in[15:14] ^ addr_in[3:2];
        if (hash_enables[0])
            amap[5:4] = amap[5:4] ^ addr_in[13:12];
        if (hash_enables[1])
            amap[1:0] = amap[1:0] ^ addr_in[11:10];
        if (hash_enables[2])
            amap[2] = amap[2] ^ addr_in[9];
        if (hash_enables[3])
            amap[7:6] = {amap[6], amap[7]};
        if (hash_enables[4])
            amap[7:6] = amap[7:6] ^ amap[5:4];
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            addr_out <= 16'h0000;
        else
            addr_out <= amap;
    end

    ////////////////////////////////////////////////////////////////
    // memory selftest sequencer
    drc_st_t st_q;
    logic [3:0] pat_len;
    logic [7:0] step_cnt_q;

    function automatic logic [2:0] step_fix(input logic [2:0] v);
        step_fix = (v == STEP_4) ? STEP_4 : (v == STEP_2) ? STEP_2 : STEP_1;
    endfunction

    assign pat_len = (bist_cfg.length < PAT_LEN_MIN) ? PAT_LEN_MIN :
                     (bist_cfg.length > PAT_LEN_MAX) ? PAT_LEN_MAX : bist_cfg.length;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_q <= DRC_ST_IDLE;
            step_cnt_q <= 8'h00;
        end
        else
        begin
            case (st_q)
                DRC_ST_IDLE:
                    if (bist_start)
                    begin
                        step_cnt_q <= 8'h00;
                        st_q <= (bist_cfg.mode == 2'b10) ? DRC_ST_EYE : DRC_ST_IFACE;
                    end
                DRC_ST_IFACE:
                    if (mclk_rise)
                    begin
                        step_cnt_q <= step_cnt_q + 8'h01;
                        if (step_cnt_q[3:0] == pat_len)
                        begin
                            step_cnt_q <= 8'h00;
                            st_q <= (bist_cfg.mode == 2'b01) ? DRC_ST_DONE : DRC_ST_EYE;
                        end
                    end
                DRC_ST_EYE:
                    if (mclk_rise)
                    begin
                        step_cnt_q <= step_cnt_q + 8'(step_fix(bist_cfg.rd_vstep));
                        if (step_cnt_q >= {4'h0, pat_len})
                            st_q <= DRC_ST_DONE;
                    end
                DRC_ST_DONE:
                    if (!bist_start)
                        st_q <= DRC_ST_IDLE;
                default: st_q <= DRC_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            bist_busy <= 1'b0;
            bist_done <= 1'b0;
            bist_pattern <= '0;
            aggressor_mask <= 3'b000;
            sweep_steps <= '0;
            per_nibble_margin <= 1'b0;
            lane_force <= '0;
            lane_value <= 1'b0;
        end
        else
        begin
            bist_busy <= (st_q == DRC_ST_IFACE) || (st_q == DRC_ST_EYE);
            bist_done <= (st_q == DRC_ST_DONE);
            bist_pattern <= {2'b00, bist_cfg.pattern, pat_len, 4'h0};
            case (bist_cfg.aggressors)
                2'b01: aggressor_mask <= 3'b001;
                2'b10: aggressor_mask <= 3'b011;
                2'b11: aggressor_mask <= 3'b111;
                default: aggressor_mask <= 3'b000;
            endcase
            sweep_steps <= {step_fix(bist_cfg.rd_vstep), step_fix(bist_cfg.rd_tstep),
                            step_fix(bist_cfg.wr_vstep), step_fix(bist_cfg.wr_tstep)};
            per_nibble_margin <= bist_cfg.per_nibble;
            // aggressor lanes take precedence: when both are enabled only the aggressor masks are applied
            if (aggressor_lanes.enable)
            begin
                lane_force <= {aggressor_lanes.upper, aggressor_lanes.lower,
                               aggressor_lanes.ecc};
                lane_value <= aggressor_lanes.static_value;
            end
            else if (target_lanes.enable)
            begin
                lane_force <= {target_lanes.upper, target_lanes.lower,
                               target_lanes.ecc};
                lane_value <= target_lanes.static_value;
            end
            else
            begin
                lane_force <= '0;
                lane_value <= 1'b0;
            end
        end
    end
endmodule

// ===== hdl/drc_pkg.sv
package drc_pkg;

    localparam int unsigned CLK_MHZ = 50;
    // refresh interval, in nanoseconds
    localparam int unsigned REFI_NORMAL_NS = 7800;
    localparam int unsigned REFI_FAST_NS = 3900;
    localparam logic [15:0] REFI_NORMAL_CYC = 16'(REFI_NORMAL_NS * CLK_MHZ / 1000);
    localparam logic [15:0] REFI_FAST_CYC = 16'(REFI_FAST_NS * CLK_MHZ / 1000);

    localparam logic [2:0] REF_BOUND_MIN = 3'h1;
    localparam logic [2:0] REF_BOUND_MAX = 3'h6;
    localparam logic [2:0] REF_SUB_DEFAULT = 3'h4;
    localparam logic [2:0] REF_URG_DEFAULT = 3'h6;
    localparam logic [3:0] REF_PEND_MAX = 4'h8;
    localparam int unsigned RANKS = 4;

    localparam logic [5:0] SETUP_MAX = 6'h27;
    localparam logic [7:0] REPLAY_MIN_VALID = 8'h04;
    localparam logic [3:0] PAT_LEN_MIN = 4'h3;
    localparam logic [3:0] PAT_LEN_MAX = 4'hc;
    localparam logic [2:0] STEP_1 = 3'h1;
    localparam logic [2:0] STEP_2 = 3'h2;
    localparam logic [2:0] STEP_4 = 3'h4;
    localparam logic [9:0] SPD_LAST_FULL = 10'h1ff;
    localparam logic [9:0] SPD_LAST_OPT = 10'h17f;
    localparam logic [3:0] SPD_MAC_NIBBLE = 4'hf;

    typedef enum logic [1:0] {
        DRC_TRI_AUTO = 2'b00,
        DRC_TRI_OFF = 2'b01,
        DRC_TRI_ON = 2'b10
    } drc_tri_t;

    typedef enum logic [1:0] {
        DRC_STAG_OFF = 2'b00,
        DRC_STAG_DIV3 = 2'b01,
        DRC_STAG_DIV4 = 2'b10
    } drc_stag_t;

    typedef enum logic [3:0] {
        DRC_MAC_AUTO = 4'h0,
        DRC_MAC_200K = 4'h1,
        DRC_MAC_300K = 4'h2,
        DRC_MAC_400K = 4'h3,
        DRC_MAC_500K = 4'h4,
        DRC_MAC_600K = 4'h5,
        DRC_MAC_700K = 4'h6,
        DRC_MAC_UNLIMITED = 4'h7,
        DRC_MAC_UNTESTED = 4'h8
    } drc_mac_t;

    typedef enum logic [1:0] {
        DRC_SYM_AUTO = 2'b00,
        DRC_SYM_X4 = 2'b01,
        DRC_SYM_X8 = 2'b10,
        DRC_SYM_X16 = 2'b11
    } drc_sym_t;

    typedef enum logic [1:0] {
        DRC_ST_IDLE = 2'b00,
        DRC_ST_IFACE = 2'b01,
        DRC_ST_EYE = 2'b10,
        DRC_ST_DONE = 2'b11
    } drc_st_t;

    typedef struct packed {
        logic [2:0] lower_bound;
        logic [2:0] urgent_threshold;
        logic fast_refresh;
        drc_stag_t stagger;
        logic [1:0] controller_index;
        logic [9:0] trfc;
    } drc_ref_cfg_t;

    typedef struct packed {
        logic [31:0] upper;
        logic [31:0] lower;
        logic [7:0] ecc;
        logic static_value;
        logic enable;
    } drc_lane_t;

    typedef struct packed {
        logic [1:0] mode;        // 1 iface, 2 eye, 3 both, 0 auto=both
        logic [1:0] pattern;     // 1 prbs, 2 switching, 3 both
        logic [3:0] length;
        logic [1:0] aggressors;  // 0 none, 1/3/7 channels
        logic per_nibble;
        logic [2:0] rd_vstep;
        logic [2:0] rd_tstep;
        logic [2:0] wr_vstep;
        logic [2:0] wr_tstep;
    } drc_bist_cfg_t;

endpackage

// ===== hdl/drc_sync.sv
`timescale 1ns/1ps
module drc_sync
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ===== verification/drc_ctrl_sva.sv
`timescale 1ns/1ps
module drc_ctrl_sva
    import drc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [1:0] command_cycle_select,
    input wire logic [7:0] parity_replay_cfg,
    input wire logic [7:0] crc_replay_cfg,
    input drc_pkg::drc_tri_t ecc_sel,
    input drc_pkg::drc_tri_t power_down_sel,
    input wire logic spd_read_optimize,
    input drc_pkg::drc_mac_t mac_override,
    input wire logic [7:0] spd_byte7,
    input wire logic self_refresh_exit,
    input wire logic two_cycle_cmd,
    input wire logic [7:0] parity_replay_limit,
    input wire logic [7:0] crc_replay_limit,
    input wire logic ecc_enable,
    input wire logic power_down_allow,
    input wire logic [9:0] spd_last_addr,
    input wire logic [3:0] max_activate_limit,
    input wire logic [17:0] setup_delays,
    input wire logic [10:0] sr_exit_extra,
    input wire logic sub_urgent,
    input wire logic urgent,
    input wire logic bist_done
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    ////////////////////////////////////////
    property p_two_cycle;
        !$past(srst) |-> two_cycle_cmd == ($past(command_cycle_select) == 2'b10);
    endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("cmd timing wrong");
    property p_replay;
        !$past(srst) |-> parity_replay_limit == (($past(parity_replay_cfg) inside {8'h01, 8'h02,
            8'h03}) ? 8'h00 : $past(parity_replay_cfg)) && crc_replay_limit ==
            (($past(crc_replay_cfg) inside {8'h01, 8'h02, 8'h03}) ? 8'h00 : $past(crc_replay_cfg));
    endproperty
    a_replay: assert property (p_replay) else $error("replay limit wrong");
    property p_ecc;
        !$past(srst) |-> ecc_enable == ($past(ecc_sel) != DRC_TRI_OFF);
    endproperty
    a_ecc: assert property (p_ecc) else $error("ecc enable wrong");
    property p_pd;
        $past(power_down_sel) == DRC_TRI_OFF && !$past(srst) |-> !power_down_allow;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down while off");
    property p_spd;
        !$past(srst) |-> spd_last_addr == ($past(spd_read_optimize) ? SPD_LAST_OPT : SPD_LAST_FULL);
    endproperty
    a_spd: assert property (p_spd) else $error("spd range wrong");
    property p_mac;
        $past(mac_override) == DRC_MAC_AUTO && !$past(srst)
            |-> max_activate_limit == $past(spd_byte7[3:0]);
    endproperty
    a_mac: assert property (p_mac) else $error("auto activate limit wrong");
    property p_setup;
        setup_delays[5:0] <= SETUP_MAX && setup_delays[11:6] <= SETUP_MAX
            && setup_delays[17:12] <= SETUP_MAX;
    endproperty
    a_setup: assert property (p_setup) else $error("setup delay above limit");
    property p_sr_hold;
        !$past(self_refresh_exit) && !$past(srst) |-> $stable(sr_exit_extra);
    endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("exit delay moved");
    property p_urg_sub;
        urgent |-> sub_urgent;
    endproperty
    a_urg_sub: assert property (p_urg_sub) else $error("urgent without sub-urgent");
    c_sub: cover property ($rose(sub_urgent));
    c_urg: cover property ($rose(urgent));
    c_bist: cover property ($rose(bist_done));
endmodule
bind drc_ctrl drc_ctrl_sva u_sva (.*);

// ===== verification/drc_ctrl_tb_top.sv
`timescale 1ns/1ps
module drc_ctrl_tb_top;
    import drc_pkg::*;
    logic ref_clk, srst, mem_clk, rw_pending, idle_hint, self_refresh_exit, respond_en;
    logic bus_timing_manual, spd_read_optimize, cs_interleave, bist_start;
    drc_ref_cfg_t ref_cfg;
    logic [RANKS-1:0] refresh_done, refresh_request;
    drc_tri_t power_down_sel, ecc_sel;
    drc_mac_t mac_override;
    drc_sym_t ecc_symbol_sel;
    drc_bist_cfg_t bist_cfg;
    drc_lane_t aggressor_lanes, target_lanes;
    logic [1:0] command_cycle_select, ecc_symbol;
    logic [5:0] addr_command_setup_delay, select_termination_setup_delay;
    logic [5:0] clock_enable_setup_delay;
    logic [7:0] spd_byte7, parity_replay_cfg, crc_replay_cfg, parity_replay_limit;
    logic [7:0] crc_replay_limit;
    logic [4:0] hash_enables;
    logic [15:0] addr_in, addr_out;
    logic sub_urgent, urgent, traffic_stall, power_down_allow, two_cycle_cmd, ecc_enable;
    logic lane_value, per_nibble_margin, bist_busy, bist_done;
    logic [10:0] sr_exit_extra;
    logic [17:0] setup_delays;
    logic [3:0] max_activate_limit;
    logic [9:0] spd_last_addr;
    logic [71:0] lane_force;
    logic [11:0] bist_pattern, sweep_steps;
    logic [2:0] aggressor_mask;
    logic [31:0] rnd;
    int n_mismatch, total_checks, refi, k;

    drc_ctrl uut (.*);
    drc_dram_model #(.LAT(3)) u_dram (.*);
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_replay(input logic [7:0] v);
        return (v inside {8'h01, 8'h02, 8'h03}) ? 8'h00 : v;
    endfunction
    function automatic logic [15:0] exp_sr(input int n, input int idx, input int trfc);
        return (n == 0) ? 16'h0000 : 16'((trfc / (n == 1 ? 3 : 4)) * idx);
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge ref_clk);
        srst = 1'b1;
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
    endtask
    task automatic drive_rand(input int i);
        rnd = lfsr(rnd);
        command_cycle_select = rnd[1:0];
        parity_replay_cfg = (i < 5) ? 8'(i) : rnd[9:2];
        crc_replay_cfg = (i < 5) ? 8'(4 - i) : rnd[17:10];
        ecc_sel = drc_tri_t'(rnd[19:18] % 3);
        power_down_sel = drc_tri_t'(rnd[21:20] % 3);
        mac_override = (i < 3) ? DRC_MAC_AUTO : drc_mac_t'(rnd[25:22] % 9);
        spd_byte7 = rnd[31:24];
        spd_read_optimize = rnd[5];
        ecc_symbol_sel = drc_sym_t'(rnd[7:6]);
        {bus_timing_manual, idle_hint, cs_interleave, hash_enables} = rnd[30:23];
        {addr_command_setup_delay, select_termination_setup_delay} = rnd[11:0];
        clock_enable_setup_delay = rnd[17:12];
        addr_in = rnd[15:0];
        bist_cfg = 23'(rnd);
        bist_cfg.length = 4'(3 + rnd[28:25] % 10);
        aggressor_lanes = 74'({rnd, ~rnd, rnd[9:0]});
        target_lanes = 74'({~rnd, rnd, rnd[19:10]});
    endtask
    ////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // a hung wait loop must not stall the run forever
    initial
    begin
        #600000;
        n_mismatch++;
        complete_run();
    end
    initial
    begin
        rnd = 32'h0000_261e;
        srst = 1'b1;
        {rw_pending, self_refresh_exit, respond_en, bist_start} = 4'h0;
        ref_cfg = '{3'h1, 3'h2, 1'b1, DRC_STAG_OFF, 2'h0, 10'h12c};
        drive_rand(5);
        do_reset();
        chk("ecc_enable", 16'h0001, 16'(ecc_enable));
        chk("spd_last_addr", 16'h01ff, 16'(spd_last_addr));
        // lower bound 1, threshold 2: both tick rates in turn
        for (int f = 1; f >= 0; f--)
        begin
            ref_cfg.fast_refresh = f[0];
            {respond_en, rw_pending} = 2'b00;
            do_reset();
            refi = f ? int'(REFI_FAST_CYC) : int'(REFI_NORMAL_CYC);
            repeat (refi - 10) @(posedge ref_clk);
            #1 chk("sub_urgent", 16'h0000, 16'(sub_urgent));
            for (k = 0; k < 20 && sub_urgent !== 1'b1; k++) @(negedge ref_clk);
            #1 chk("sub_urgent", 16'h0001, 16'(sub_urgent));
            chk("urgent", 16'h0000, 16'(urgent));
            repeat (refi - 20) @(posedge ref_clk);
            #1 chk("urgent", 16'h0000, 16'(urgent));
            for (k = 0; k < 40 && urgent !== 1'b1; k++) @(negedge ref_clk);
            #1 chk("urgent", 16'h0001, 16'(urgent));
            @(negedge ref_clk) rw_pending = 1'b1;
            repeat (3) @(posedge ref_clk);
            #1 chk("traffic_stall", 16'h0001, 16'(traffic_stall));
            @(negedge ref_clk) respond_en = 1'b1;
            repeat (60) @(posedge ref_clk);
            #1 chk("urgent", 16'h0000, 16'({urgent, sub_urgent}));
        end
        for (int j = 0; j < 3; j++)
        begin
            @(negedge ref_clk);
            ref_cfg.stagger = drc_stag_t'(j);
            ref_cfg.controller_index = 2'(j + 1);
            @(negedge ref_clk) self_refresh_exit = 1'b1;
            @(negedge ref_clk) self_refresh_exit = 1'b0;
            repeat (3) @(posedge ref_clk);
            #1 chk("sr_exit_extra", exp_sr(j, j + 1, 300), 16'(sr_exit_extra));
        end
        for (int i = 0; i < 40; i++)
        begin
            @(negedge ref_clk) drive_rand(i);
            repeat (2) @(posedge ref_clk);
            #1 chk("two_cycle_cmd", 16'(command_cycle_select == 2'b10), 16'(two_cycle_cmd));
            chk("parity_limit", 16'(exp_replay(parity_replay_cfg)), 16'(parity_replay_limit));
            chk("crc_limit", 16'(exp_replay(crc_replay_cfg)), 16'(crc_replay_limit));
            chk("ecc_enable", 16'(ecc_sel != DRC_TRI_OFF), 16'(ecc_enable));
            chk("spd_last", 16'(spd_read_optimize ? 10'h17f : 10'h1ff), 16'(spd_last_addr));
            if (mac_override == DRC_MAC_AUTO)
                chk("mac", 16'(spd_byte7[3:0]), 16'(max_activate_limit));
            else
                chk("mac", 16'(mac_override), 16'(max_activate_limit));
            if (power_down_sel == DRC_TRI_OFF)
                chk("power_down", 16'h0000, 16'(power_down_allow));
            chk("ecc_symbol", 16'(ecc_symbol_sel), 16'(ecc_symbol));
            chk("aggressors", 16'((1 << bist_cfg.aggressors) - 1), 16'(aggressor_mask));
            chk("per_nibble", 16'(bist_cfg.per_nibble), 16'(per_nibble_margin));
            chk("bist_pattern", 16'({bist_cfg.pattern, bist_cfg.length, 4'h0}),
                16'(bist_pattern));
        end
        for (int m = 0; m < 4; m++)
        begin
            @(negedge ref_clk);
            bist_cfg.mode = 2'(m);
            bist_start = 1'b1;
            for (k = 0; k < 5000 && bist_done !== 1'b1; k++) @(negedge ref_clk);
            #1 chk("bist_done", 16'h0001, 16'(bist_done));
            chk("bist_busy", 16'h0000, 16'(bist_busy));
            @(negedge ref_clk) bist_start = 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        complete_run();
    end
endmodule

// ===== verification/drc_dram_model.sv
`timescale 1ns/1ps
module drc_dram_model
    import drc_pkg::*;
#(
    parameter int LAT = 3
)
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic respond_en,
    input wire logic [RANKS-1:0] refresh_request,
    output logic mem_clk,
    output logic [RANKS-1:0] refresh_done
);
    int wait_q;
    // memory clock free-runs, phase unrelated to ref_clk
    initial
    begin
        mem_clk = 1'b0;
        refresh_done = '0;
        wait_q = 0;
        #13;
        forever #80 mem_clk = ~mem_clk;
    end
    // answers each pending rank after LAT+1 cycles; respond_en low holds answers off and restarts the wait
    always @(posedge ref_clk)
    begin
        refresh_done <= '0;
        wait_q <= 0;
        if (!srst && respond_en && refresh_request != '0)
        begin
            wait_q <= (wait_q == LAT) ? 0 : wait_q + 1;
            if (wait_q == LAT)
                refresh_done <= refresh_request;
        end
    end
endmodule
